// ### dpllcf_top.sv
// dpllcf_top: configuration bank for the first digital loop's feedback divider
// on the fourth reference input and the second digital loop's free-run,
// oscillator, pull-in clamp and holdover history settings.
// assumes an apb master on mclk and loop logic on mclk for the tuning word.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module dpllcf_top
  import dpllcf_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES          // cycles per ms, shorten in sim
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // loop side
  input  wire logic [FREE_W-1:0] loopTuneWord,
  input  wire logic              refSwitch,
  output dpllcf_cfg_t            cfg,
  output dpllcf_hold_t           hold
);

  // slot lookup: hit flag above the slot number
  function automatic logic [SLOT_W:0] findSlot(input logic [ADDR_W-1:0] a);
    logic [SLOT_W:0] r;
    r = '0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (a[ADDR_W-1:2] == REG_INDEX[i] && a[1:0] == 2'b00)
        r = {1'b1, SLOT_W'(i)};
    end
    return r;
  endfunction

  // legal oscillator integer codes
  function automatic logic oscLegal(input logic [4:0] code);
    return code == OSC_DIV_FOUR ||
           (code >= OSC_DIV_RUN_MIN && code <= OSC_DIV_RUN_MAX);
  endfunction

  // register storage
  logic [7:0]        regByte_r [NUM_REGS];    // one byte per slot
  logic [4:0]        oscEff_r;                // divide code in use
  logic              oscBad_r;                // illegal code was written

  // bus state
  logic [SLOT_W-1:0] slot_r;                  // slot decoded at setup
  logic              hit_r;                   // setup hit a byte register
  logic [SLOT_W:0]   lookup;                  // combinational decode
  logic              isStatus;                // setup hits the status word
  logic              setupPhase;              // first cycle of a transfer
  logic              writeDone;               // write takes effect now
  logic [7:0]        wrByte;                  // masked write byte

  // history state
  logic              msTick;                  // one-ms pulse
  logic              intervalDone;            // averaging period ended
  logic [FREE_W-1:0] iir_r;                   // running average
  logic [FREE_W-1:0] histWord_r;              // average at last interval end
  logic              historyValid_r;          // histWord_r is usable
  logic              historyUpdate_r;         // histWord_r just refreshed
  logic [FREE_W-1:0] holdWord_r;              // word offered for holdover
  logic [FREE_W:0]   iirDiff;                 // sample minus average
  logic [FREE_W:0]   iirSum;                  // next average, unsigned
  logic signed [FREE_W:0] iirStep;            // scaled step, sign kept

  // decode and write qualification
  always_comb
  begin
    setupPhase = psel && !penable;
    lookup     = findSlot(paddr);
    isStatus   = paddr[ADDR_W-1:2] == STATUS_INDEX && paddr[1:0] == 2'b00;
    writeDone  = psel && penable && pready && pwrite && hit_r && pstrb[0];
    wrByte     = pwdata[7:0] & REG_MASK[slot_r];
  end

  // apb answer: decoded and read at setup, ready in the access cycle
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
      slot_r  <= '0;
      hit_r   <= 1'b0;
    end
    else if (setupPhase)
    begin
      pready  <= 1'b1;
      slot_r  <= lookup[SLOT_W-1:0];
      hit_r   <= lookup[SLOT_W];
      pslverr <= !lookup[SLOT_W] && !isStatus;     // unmapped address
      if (pwrite || !(lookup[SLOT_W] || isStatus))
        prdata <= '0;
      else if (isStatus)
      begin
        // device state, other bits zero
        prdata                      <= '0;
        prdata[STAT_HIST_VALID_BIT] <= historyValid_r;
        prdata[STAT_OSC_BAD_BIT]    <= oscBad_r;
      end
      else
        prdata <= {24'h0, regByte_r[lookup[SLOT_W-1:0]]};
    end
    else
    begin
      // access completes at this edge; drop ready behind it
      pready  <= 1'b0;
      pslverr <= 1'b0;
      hit_r   <= 1'b0;
    end
  end

  // byte storage with per-slot reset and reserved masks
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      // documented defaults
      for (int i = 0; i < NUM_REGS; i++)
        regByte_r[i] <= REG_RESET[i];
    end
    else if (writeDone)
      regByte_r[slot_r] <= wrByte;              // reserved bits forced low
  end

  // oscillator divide in use follows legal codes only
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      oscEff_r <= REG_RESET[SLOT_OSC][4:0];
      oscBad_r <= 1'b0;
    end
    else if (writeDone && slot_r == SLOT_OSC)
    begin
      if (oscLegal(wrByte[4:0]))
      begin
        oscEff_r <= wrByte[4:0];
        oscBad_r <= 1'b0;
      end
      else
        oscBad_r <= 1'b1;                       // keep last legal divide
    end
  end

  // field assembly straight from the byte flops; oscillator divide from oscEff_r
  always_comb
  begin
    // stored value is ratio minus one, bit 16 in the top byte
    cfg.intDivMinusOne = {regByte_r[SLOT_INT_HI][0], regByte_r[SLOT_INT_MID],
                          regByte_r[SLOT_INT_LO]};
    cfg.fracNumerator  = {regByte_r[SLOT_NUM_HI][6:0], regByte_r[SLOT_NUM_MID],
                          regByte_r[SLOT_NUM_LO]};
    cfg.fracModulus    = {regByte_r[SLOT_MOD_HI][6:0], regByte_r[SLOT_MOD_MID],
                          regByte_r[SLOT_MOD_LO]};
    cfg.freeRunWord    = {regByte_r[SLOT_FREE_B3][5:0], regByte_r[SLOT_FREE_B2],
                          regByte_r[SLOT_FREE_B1], regByte_r[SLOT_FREE_B0]};
    cfg.oscDivide      = oscEff_r;
    cfg.clampLower     = {regByte_r[SLOT_LOW_HI][3:0], regByte_r[SLOT_LOW_MID],
                          regByte_r[SLOT_LOW_LO]};
    cfg.clampUpper     = {regByte_r[SLOT_UP_HI][3:0], regByte_r[SLOT_UP_MID],
                          regByte_r[SLOT_UP_LO]};
    cfg.historyMs      = {regByte_r[SLOT_HIST_HI], regByte_r[SLOT_HIST_LO]};
  end

  // ms time base and averaging interval from the history timer
  dpllcf_hist_timer #(
    .MsCycles     (MsCycles)
  ) u_timer (
    .mclk         (mclk),
    .rstn         (rstn),
    .intervalMs   (cfg.historyMs),
    .restart      (refSwitch),
    .msTick       (msTick),
    .intervalDone (intervalDone)
  );

  // smoothing step, one sample per millisecond
  always_comb
  begin
    iirDiff = {1'b0, loopTuneWord} - {1'b0, iir_r};
    // shift on its own so a falling word keeps its sign
    iirStep = $signed(iirDiff) >>> HIST_IIR_SHIFT;
    iirSum  = {1'b0, iir_r} + $unsigned(iirStep);
  end

  // running average of the loop tuning word
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      iir_r <= '0;
    else if (refSwitch)
      iir_r <= loopTuneWord;                    // new reference, new average
    else if (msTick)
      iir_r <= iirSum[FREE_W-1:0];
  end

  // history capture at each interval end; capture wins over a clear
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      histWord_r      <= '0;
      historyValid_r  <= 1'b0;
      historyUpdate_r <= 1'b0;
    end
    else
    begin
      historyUpdate_r <= intervalDone;
      if (intervalDone)
      begin
        histWord_r     <= iir_r;
        historyValid_r <= 1'b1;
      end
      else if (refSwitch)
        historyValid_r <= 1'b0;
    end
  end

  // holdover word: history if any, else the free-run word
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      holdWord_r <= '0;
    else
      holdWord_r <= historyValid_r ? histWord_r : cfg.freeRunWord;
  end

  // holdover outputs
  always_comb
  begin
    hold.holdoverWord  = holdWord_r;
    hold.historyValid  = historyValid_r;
    hold.historyUpdate = historyUpdate_r;
  end

  // integer divide low byte stores the written byte
  a_int_div_store: assert property (
    @(posedge mclk) disable iff (!rstn)
    writeDone && slot_r == SLOT_INT_LO
      |=> cfg.intDivMinusOne[7:0] == $past(pwdata[7:0]))
    else $error("integer divide low byte not stored");

  // numerator top byte drops its reserved bit
  a_num_top_mask: assert property (
    @(posedge mclk) disable iff (!rstn)
    writeDone && slot_r == SLOT_NUM_HI
      |=> regByte_r[SLOT_NUM_HI] == ($past(pwdata[7:0]) & 8'h7f))
    else $error("numerator top byte masked wrongly");

  // modulus reserved bit stays low
  a_mod_reserved: assert property (
    @(posedge mclk) disable iff (!rstn)
    regByte_r[SLOT_MOD_HI][7] == 1'b0)
    else $error("modulus reserved bit set");

  // free-run top byte reserved bits stay low
  a_free_reserved: assert property (
    @(posedge mclk) disable iff (!rstn)
    regByte_r[SLOT_FREE_B3][7:6] == 2'b00)
    else $error("free-run reserved bits set");

  // illegal oscillator code leaves the divide unchanged
  a_osc_hold_bad: assert property (
    @(posedge mclk) disable iff (!rstn)
    writeDone && slot_r == SLOT_OSC && !oscLegal(pwdata[4:0])
      |=> oscEff_r == $past(oscEff_r) && oscBad_r)
    else $error("illegal oscillator code accepted");

  // lower clamp top nibble reserved
  a_low_reserved: assert property (
    @(posedge mclk) disable iff (!rstn)
    regByte_r[SLOT_LOW_HI][7:4] == 4'h0)
    else $error("lower clamp reserved nibble set");

  // upper clamp top nibble reserved
  a_up_reserved: assert property (
    @(posedge mclk) disable iff (!rstn)
    regByte_r[SLOT_UP_HI][7:4] == 4'h0)
    else $error("upper clamp reserved nibble set");

  // interval end refreshes history two cycles on the holdover word
  a_hist_capture: assert property (
    @(posedge mclk) disable iff (!rstn)
    intervalDone |=> historyValid_r && historyUpdate_r
      ##1 holdWord_r == $past(histWord_r))
    else $error("history not captured at interval end");

  // without history the holdover word tracks the free-run word
  a_hold_fallback: assert property (
    @(posedge mclk) disable iff (!rstn)
    !historyValid_r |=> holdWord_r == $past(cfg.freeRunWord))
    else $error("holdover word ignores free-run word");

  // read data upper bytes zero on a register read
  a_read_upper: assert property (
    @(posedge mclk) disable iff (!rstn)
    psel && penable && pready && !pwrite && hit_r |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");

endmodule

// ### dpllcf_pkg.sv
// dpllcf_pkg: constants and carrier types for the loop divider and holdover
// configuration bank.
// assumes a 100 MHz mclk and byte-wide registers placed one per APB word.
package dpllcf_pkg;

  // bus shape
  localparam int ADDR_W   = 16;              // apb byte address width
  localparam int DATA_W   = 32;              // apb data width
  localparam int IDX_W    = ADDR_W - 2;      // register index width
  localparam int NUM_REGS = 22;              // byte registers in the bank
  localparam int SLOT_W   = 5;               // width of a slot number

  // time base
  localparam int CLK_PERIOD_NS = 10;         // mclk period
  localparam int MS_TIME_NS    = 1000000;    // one history timer unit
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] REG_INDEX [NUM_REGS] = '{
    14'h046b, 14'h046c, 14'h046d,            // integer feedback divide
    14'h046e, 14'h046f, 14'h0470,            // fractional numerator
    14'h0471, 14'h0472, 14'h0473,            // fractional modulus
    14'h0500, 14'h0501, 14'h0502, 14'h0503,  // free-run tuning word
    14'h0504,                                // oscillator integer divide
    14'h0505, 14'h0506, 14'h0507,            // pull-in lower limit
    14'h0508, 14'h0509, 14'h050a,            // pull-in upper limit
    14'h050b, 14'h050c                       // history timer
  };

  // reset values, slot by slot
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{
    8'hcb, 8'h07, 8'h00, 8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00,
    8'h12, 8'h15, 8'h64, 8'h1b, 8'h08,
    8'h51, 8'hb8, 8'h02, 8'h3e, 8'h0a, 8'h0b, 8'h0a, 8'h00
  };

  // writable bits; reserved bits are held at zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h7f,
    8'hff, 8'hff, 8'hff, 8'h3f, 8'h1f,
    8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff
  };

  // read-only status register
  localparam logic [IDX_W-1:0] STATUS_INDEX = 14'h0530;
  localparam int STAT_HIST_VALID_BIT = 0;    // history average available
  localparam int STAT_OSC_BAD_BIT    = 1;    // last oscillator code illegal

  // slot numbers
  localparam logic [SLOT_W-1:0] SLOT_INT_LO  = 5'h00;
  localparam logic [SLOT_W-1:0] SLOT_INT_MID = 5'h01;
  localparam logic [SLOT_W-1:0] SLOT_INT_HI  = 5'h02;
  localparam logic [SLOT_W-1:0] SLOT_NUM_LO  = 5'h03;
  localparam logic [SLOT_W-1:0] SLOT_NUM_MID = 5'h04;
  localparam logic [SLOT_W-1:0] SLOT_NUM_HI  = 5'h05;
  localparam logic [SLOT_W-1:0] SLOT_MOD_LO  = 5'h06;
  localparam logic [SLOT_W-1:0] SLOT_MOD_MID = 5'h07;
  localparam logic [SLOT_W-1:0] SLOT_MOD_HI  = 5'h08;
  localparam logic [SLOT_W-1:0] SLOT_FREE_B0 = 5'h09;
  localparam logic [SLOT_W-1:0] SLOT_FREE_B1 = 5'h0a;
  localparam logic [SLOT_W-1:0] SLOT_FREE_B2 = 5'h0b;
  localparam logic [SLOT_W-1:0] SLOT_FREE_B3 = 5'h0c;
  localparam logic [SLOT_W-1:0] SLOT_OSC     = 5'h0d;
  localparam logic [SLOT_W-1:0] SLOT_LOW_LO  = 5'h0e;
  localparam logic [SLOT_W-1:0] SLOT_LOW_MID = 5'h0f;
  localparam logic [SLOT_W-1:0] SLOT_LOW_HI  = 5'h10;
  localparam logic [SLOT_W-1:0] SLOT_UP_LO   = 5'h11;
  localparam logic [SLOT_W-1:0] SLOT_UP_MID  = 5'h12;
  localparam logic [SLOT_W-1:0] SLOT_UP_HI   = 5'h13;
  localparam logic [SLOT_W-1:0] SLOT_HIST_LO = 5'h14;
  localparam logic [SLOT_W-1:0] SLOT_HIST_HI = 5'h15;

  // field widths and codes
  localparam int FREE_W = 30;                 // free-run tuning word
  localparam int HIST_W = 16;                 // history timer in ms
  localparam logic [4:0] OSC_DIV_FOUR    = 5'h04;
  localparam logic [4:0] OSC_DIV_RUN_MIN = 5'h06;
  localparam logic [4:0] OSC_DIV_RUN_MAX = 5'h0f;
  localparam int HIST_IIR_SHIFT = 4;          // smoothing of the history

  // configuration fields handed to the loop
  typedef struct packed {
    logic [16:0] intDivMinusOne;              // ratio minus one
    logic [22:0] fracNumerator;
    logic [22:0] fracModulus;
    logic [29:0] freeRunWord;
    logic [4:0]  oscDivide;                   // last legal code only
    logic [19:0] clampLower;
    logic [19:0] clampUpper;
    logic [15:0] historyMs;
  } dpllcf_cfg_t;

  // holdover result handed to the loop
  typedef struct packed {
    logic [29:0] holdoverWord;
    logic        historyValid;
    logic        historyUpdate;               // one-cycle pulse
  } dpllcf_hold_t;

endpackage

// ### dpllcf_hist_timer.sv
// dpllcf_hist_timer: millisecond time base and history interval counter.
// assumes restart and the interval come from logic on mclk.
`timescale 1ns/1ps
module dpllcf_hist_timer
  import dpllcf_pkg::*;
#(
  parameter int MsCycles = MS_CYCLES          // cycles in one millisecond
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // control
  input  wire logic [HIST_W-1:0] intervalMs,
  input  wire logic              restart,
  // events
  output logic                   msTick,
  output logic                   intervalDone
);

  localparam int CNT_W = $clog2(MsCycles + 1);

  logic [CNT_W-1:0]  tickCnt_r;               // cycles within a ms
  logic [HIST_W-1:0] msCnt_r;                 // ms within the interval
  logic [HIST_W:0]   intervalEff;             // interval, zero forced to one
  logic [HIST_W:0]   msNext;                  // ms count after this tick

  // a zero timer is illegal; run it as one ms rather than never
  always_comb
  begin
    intervalEff = (intervalMs == '0) ? (HIST_W+1)'(1) : {1'b0, intervalMs};
    msNext      = {1'b0, msCnt_r} + (HIST_W+1)'(1);
  end

  // millisecond divider, one-cycle tick
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt_r <= '0;
      msTick    <= 1'b0;
    end
    else if (restart || tickCnt_r == CNT_W'(MsCycles - 1))
    begin
      tickCnt_r <= '0;
      msTick    <= !restart;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + CNT_W'(1);
      msTick    <= 1'b0;
    end
  end

  // interval counter in ms units
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      msCnt_r      <= '0;
      intervalDone <= 1'b0;
    end
    else if (restart)
    begin
      msCnt_r      <= '0;
      intervalDone <= 1'b0;
    end
    else if (msTick && msNext >= intervalEff)
    begin
      msCnt_r      <= '0;
      intervalDone <= 1'b1;                    // averaging period ends
    end
    else
    begin
      if (msTick)
        msCnt_r <= msNext[HIST_W-1:0];
      intervalDone <= 1'b0;
    end
  end

  // interval ends only on a millisecond boundary
  a_done_tick_order: assert property (
    @(posedge mclk) disable iff (!rstn)
    intervalDone |-> $past(msTick))
    else $error("interval ended off a millisecond tick");

endmodule

// ### tb_dpllcf_top.sv
// tb_dpllcf_top: self-checking bench for the loop divider and holdover bank.
// assumes the apb slave answers one cycle after setup and MsCycles is 10.
`timescale 1ns/1ps
module tb_dpllcf_top
  import dpllcf_pkg::*;
;
  localparam int MsSim = 10;              // shortened millisecond
  // clock and reset
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  // apb master side
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [DATA_W-1:0] pwdata  = '0;
  logic [3:0]        pstrb   = 4'hf;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  // loop side
  logic [FREE_W-1:0] loopTuneWord = 30'h0123456;
  logic              refSwitch    = 1'b0;
  dpllcf_cfg_t       cfg;
  dpllcf_hold_t      hold;
  // score
  int miscompares    = 0;
  int samples_checked = 0;
  logic [DATA_W-1:0] rd;                  // last read data
  logic              er;                  // last error flag

  always #5 mclk = ~mclk;

  dpllcf_top #(.MsCycles(MsSim)) uut (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loopTuneWord(loopTuneWord),
    .refSwitch(refSwitch), .cfg(cfg), .hold(hold)
  );

  // one compare, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [15:0] ba(input int i);
    ba = {REG_INDEX[i], 2'b00};
  endfunction

  // reset values of every byte register and of the loop fields
  task automatic t_reset;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      apb(1'b0, ba(i), 32'h0);
      chk(rd, {24'h0, REG_RESET[i]});
    end
    chk(cfg.intDivMinusOne, 32'h007cb);
    chk(cfg.fracNumerator, 32'h4);
    chk(cfg.fracModulus, 32'h5);
    chk(cfg.freeRunWord, 32'h1b641512);
    chk(cfg.oscDivide, 32'h8);
    chk(cfg.clampLower, 32'h2b851);
    chk(cfg.clampUpper, 32'hb0a3e);
    chk(cfg.historyMs, 32'ha);
    $display("test reset values done");
  endtask

  // history interval follows the timer; valid cleared by switch
  task automatic t_history;
    int n;
    apb(1'b1, ba(SLOT_HIST_LO), 32'h2);
    apb(1'b1, ba(SLOT_HIST_HI), 32'h0);
    @(posedge mclk);
    refSwitch <= 1'b1;
    @(posedge mclk);
    refSwitch <= 1'b0;
    @(negedge mclk);
    chk(hold.historyValid, 32'h0);
    n = 1;
    while (hold.historyUpdate !== 1'b1 && n < 100)
    begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n >= 2 * MsSim && n <= 2 * MsSim + 3), 32'h1);
    chk(hold.historyValid, 32'h1);
    @(negedge mclk);
    chk(hold.holdoverWord, 32'h0123456);
    $display("test history interval done");
  endtask

  // oscillator codes 0 to 15; output keeps the last legal one
  task automatic t_osc;
    logic [4:0] last;
    last = 5'h08;
    for (int c = 0; c < 16; c++)
    begin
      apb(1'b1, ba(SLOT_OSC), 32'(c));
      apb(1'b0, ba(SLOT_OSC), 32'h0);
      if (c == 4 || c >= 6)
      begin
        last = 5'(c);
      end
      chk(rd, 32'(c));
      chk(cfg.oscDivide, {27'h0, last});
    end
    $display("test oscillator codes done");
  endtask

  // all ones written; reserved bits read zero; masked strobe ignored
  task automatic t_mask;
    for (int i = 0; i < NUM_REGS - 2; i++)
    begin
      apb(1'b1, ba(i), 32'hffff_ffff);
      apb(1'b0, ba(i), 32'h0);
      chk(rd, {24'h0, REG_MASK[i]});
    end
    @(negedge mclk);
    chk(cfg.intDivMinusOne, 32'h1ffff);
    chk(cfg.fracNumerator, 32'h7fffff);
    chk(cfg.fracModulus, 32'h7fffff);
    chk(cfg.freeRunWord, 32'h3fffffff);
    chk(cfg.clampLower, 32'hfffff);
    chk(cfg.clampUpper, 32'hfffff);
    apb(1'b1, ba(SLOT_HIST_HI), 32'h0000_00ff);
    apb(1'b0, ba(SLOT_HIST_HI), 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, ba(SLOT_HIST_HI), 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, ba(SLOT_NUM_LO), 32'h5a);
    pstrb <= 4'hf;
    apb(1'b0, ba(SLOT_NUM_LO), 32'h0);
    chk(rd, 32'hff);
    $display("test field masking done");
  endtask

  // unmapped, unaligned and read-only places
  task automatic t_errors;
    apb(1'b0, 16'h0000, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, ba(SLOT_INT_LO) | 16'h0001, 32'h11);
    chk(er, 32'h1);
    apb(1'b0, ba(SLOT_INT_LO), 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, {STATUS_INDEX, 2'b00}, 32'hff);
    chk(er, 32'h0);
    apb(1'b0, {STATUS_INDEX, 2'b00}, 32'h0);
    chk({er, rd[31:2]}, 32'h0);
    chk(rd, 32'h3);
    $display("test error responses done");
  endtask

  // counts and verdict
  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog on a generous span
  initial
  begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    results;
  end

  // main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk(hold.holdoverWord, 32'h1b641512);
    t_reset;
    t_history;
    t_osc;
    t_mask;
    t_errors;
    results;
  end
endmodule
